// ===== include/mac_unit_pkg.sv
// Package with the constants, encodings and carrier types of the multiply/accumulate unit.
package mac_unit_pkg;

  // ==========================================================================
  // Widths and field positions
  // ==========================================================================
  localparam int WORD_W       = 16;
  localparam int PROD_W       = 32;
  localparam int ACC_W        = 40;
  localparam int TOP_W        = 8;
  localparam int MID_LSB      = 16;
  localparam int TOP_LSB      = 32;
  localparam int OVF_BITS     = 9;
  localparam int BANK_BIT     = 0;
  localparam int INT_MODE_BIT = 4;
  localparam int MODE_W       = 16;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0]  TOP_RESET  = 8'h00;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  typedef enum logic [1:0] {OP_MUL, OP_MAC_ADD, OP_MAC_SUB, OP_CLEAR} mac_op_t;
  typedef enum logic [2:0] {
    XS_OPA, XS_OPB, XS_ALU, XS_ACC_LO, XS_ACC_MID, XS_ACC_TOP, XS_SHF_LO, XS_SHF_HI
  } x_sel_t;
  typedef enum logic [1:0] {YS_OPA, YS_OPB, YS_FEEDBACK} y_sel_t;
  // Register addresses seen by the data-memory bus.
  typedef enum logic [2:0] {
    RA_X_A, RA_X_B, RA_Y_A, RA_Y_B, RA_ACC_LO, RA_ACC_MID, RA_ACC_TOP, RA_NONE
  } reg_addr_t;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic    valid;
    mac_op_t op;
    x_sel_t  xSel;
    y_sel_t  ySel;
    logic    xSigned;
    logic    ySigned;
    logic    toFeedback;
  } mac_cmd_t;

  typedef struct packed {
    logic        wrEn;
    reg_addr_t   wrAddr;
    logic [15:0] wrData;
    reg_addr_t   rdAddr;
  } dm_access_t;

endpackage

// ===== rtl/multiply_accumulate_unit.sv
// Multiply/accumulate datapath with banked operand, feedback and accumulator registers.
//
// Operation
// - Multiplier takes 16-bit X and Y operands, gives 32-bit product.
// - 40-bit adder adds, subtracts, or passes product into accumulator.
// - Accumulator is low word, middle word and top byte sections.
// - Overflow flag set when top nine accumulator bits differ.
// - X comes from X file, ALU result, accumulator sections or shifter results.
// - Y comes only from Y file registers or the feedback register.
// - X file read/written by data bus; dual-ported to multiplier and bus.
// - Y file data-bus RW, program-bus writable, dual-ported like X file.
// - Result goes to accumulator or feedback; feedback takes bits 16 to 31.
// - Accumulator sections load from data bus, drive data or result bus.
// - Reads see old value; writes visible from the next cycle.
// - Two register banks; mode bit 0 selects primary or alternate.
// - Operations are multiply, multiply-add, multiply-subtract, clear.
// - Fractional mode shifts product left one, zero LSB, sign-extended.
// - Integer mode passes the product unshifted.
// - Mode bit 4 high selects integer, low selects fractional.
// - Each instruction picks X and Y signedness independently.
// - Top byte sits on low bus bits, sign-extended to 16 on output.
// - Loading the middle word fills the top byte with its sign.
// - Loading the low word leaves other sections alone, no extension.
// - Overflow flag is updated on every unit operation.
`timescale 1ns/1ps

module multiply_accumulate_unit
  import mac_unit_pkg::*;
#(
  parameter int NUM_BANKS = 2
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] modeStatus,
  input  wire mac_cmd_t    cmd,
  input  wire logic [15:0] aluResult,
  input  wire logic [15:0] shifterResultLow,
  input  wire logic [15:0] shifterResultHigh,
  input  wire dm_access_t  dataMemAccess,
  input  wire logic        progBusWrEn,
  input  wire logic        progBusSelB,
  input  wire logic [15:0] progBusData,
  output logic      [15:0] dataBusOut,
  output logic      [15:0] resultBusOut,
  output logic             multiplyOverflowFlag,
  output logic             overflowValid
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (NUM_BANKS != 2) begin : g_bad_banks
    $error("multiply_accumulate_unit supports exactly two register banks");
  end

  // ==========================================================================
  // Banked register storage
  // ==========================================================================
  logic [15:0] xOperand_reg [NUM_BANKS][2];
  logic [15:0] yOperand_reg [NUM_BANKS][2];
  logic [15:0] accLow_reg   [NUM_BANKS];
  logic [15:0] accMid_reg   [NUM_BANKS];
  logic [7:0]  accTop_reg   [NUM_BANKS];
  logic [15:0] feedback_reg [NUM_BANKS];

  logic        bank;
  logic [39:0] accNow;
  logic [15:0] accTopExt;
  logic [15:0] xOperand;
  logic [15:0] yOperand;
  logic [32:0] xExt;
  logic [32:0] yExt;
  logic [65:0] fullProd;
  logic [31:0] product;
  logic [39:0] prodAligned;
  logic [39:0] macResult;
  logic        ovf;

  // Active bank comes straight from the mode word.
  assign bank      = modeStatus[BANK_BIT];
  assign accNow    = {accTop_reg[bank], accMid_reg[bank], accLow_reg[bank]};
  assign accTopExt = {{(WORD_W - TOP_W){accTop_reg[bank][TOP_W-1]}}, accTop_reg[bank]};

  // ==========================================================================
  // Operand selection
  // ==========================================================================
  // Operands are read from register outputs, so they hold last cycle's values.
  always_comb begin
    unique case (cmd.xSel)
      XS_OPA:     xOperand = xOperand_reg[bank][0];
      XS_OPB:     xOperand = xOperand_reg[bank][1];
      XS_ALU:     xOperand = aluResult;
      XS_ACC_LO:  xOperand = accLow_reg[bank];
      XS_ACC_MID: xOperand = accMid_reg[bank];
      XS_ACC_TOP: xOperand = accTopExt;
      XS_SHF_LO:  xOperand = shifterResultLow;
      XS_SHF_HI:  xOperand = shifterResultHigh;
    endcase
  end

  // Y port has only the Y file and the feedback register as sources.
  always_comb begin
    unique case (cmd.ySel)
      YS_OPA:      yOperand = yOperand_reg[bank][0];
      YS_OPB:      yOperand = yOperand_reg[bank][1];
      YS_FEEDBACK: yOperand = feedback_reg[bank];
      default:     yOperand = yOperand_reg[bank][0];
    endcase
  end

  // ==========================================================================
  // Multiplier and adder/subtracter
  // ==========================================================================
  // Each operand is widened to 33 bits per its own signedness flag.
  assign xExt     = {{17{cmd.xSigned & xOperand[15]}}, xOperand};
  assign yExt     = {{17{cmd.ySigned & yOperand[15]}}, yOperand};
  assign fullProd = $signed(xExt) * $signed(yExt);
  assign product  = fullProd[PROD_W-1:0];

  // Product alignment: integer keeps bit 0 at bit 0, fractional shifts one left.
  always_comb begin
    if (modeStatus[INT_MODE_BIT]) begin
      prodAligned = {{(ACC_W - PROD_W){fullProd[PROD_W]}}, product};
    end else begin
      prodAligned = {{(ACC_W - PROD_W - 1){fullProd[PROD_W]}}, product, 1'b0};
    end
  end

  // Adder/subtracter chooses between pass, add, subtract and clear.
  always_comb begin
    unique case (cmd.op)
      OP_MUL:     macResult = prodAligned;
      OP_MAC_ADD: macResult = accNow + prodAligned;
      OP_MAC_SUB: macResult = accNow - prodAligned;
      OP_CLEAR:   macResult = '0;
    endcase
  end

  // Overflow when the top nine bits are not all ones or all zeros.
  assign ovf = ~((&macResult[ACC_W-1:ACC_W-OVF_BITS]) | ~(|macResult[ACC_W-1:ACC_W-OVF_BITS]));

  // ==========================================================================
  // Register updates, one process per register group
  // ==========================================================================
  // Operand files: data bus writes, program bus writes the Y file.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < 2; i++) begin
          xOperand_reg[b][i] <= WORD_RESET;
          yOperand_reg[b][i] <= WORD_RESET;
        end
      end
    end else begin
      if (dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_X_A) begin
        xOperand_reg[bank][0] <= dataMemAccess.wrData;
      end
      if (dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_X_B) begin
        xOperand_reg[bank][1] <= dataMemAccess.wrData;
      end
      if (dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_Y_A) begin
        yOperand_reg[bank][0] <= dataMemAccess.wrData;
      end else if (progBusWrEn && !progBusSelB) begin
        yOperand_reg[bank][0] <= progBusData;
      end
      if (dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_Y_B) begin
        yOperand_reg[bank][1] <= dataMemAccess.wrData;
      end else if (progBusWrEn && progBusSelB) begin
        yOperand_reg[bank][1] <= progBusData;
      end
    end
  end

  // Accumulator: a bus load of a section takes priority over a result write.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        accLow_reg[b] <= WORD_RESET;
        accMid_reg[b] <= WORD_RESET;
        accTop_reg[b] <= TOP_RESET;
      end
    end else if (dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_ACC_LO) begin
      accLow_reg[bank] <= dataMemAccess.wrData;
    end else if (dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_ACC_MID) begin
      accMid_reg[bank] <= dataMemAccess.wrData;
      accTop_reg[bank] <= {TOP_W{dataMemAccess.wrData[15]}};
    end else if (dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_ACC_TOP) begin
      accTop_reg[bank] <= dataMemAccess.wrData[TOP_W-1:0];
    end else if (cmd.valid && !cmd.toFeedback) begin
      accLow_reg[bank] <= macResult[MID_LSB-1:0];
      accMid_reg[bank] <= macResult[TOP_LSB-1:MID_LSB];
      accTop_reg[bank] <= macResult[ACC_W-1:TOP_LSB];
    end
  end

  // Feedback register takes result bits 16 to 31.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        feedback_reg[b] <= WORD_RESET;
      end
    end else if (cmd.valid && cmd.toFeedback) begin
      feedback_reg[bank] <= macResult[TOP_LSB-1:MID_LSB];
    end
  end

  // Overflow flag is refreshed on every executed operation.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      multiplyOverflowFlag <= 1'b0;
      overflowValid        <= 1'b0;
    end else begin
      overflowValid <= cmd.valid;
      if (cmd.valid) begin
        multiplyOverflowFlag <= ovf;
      end
    end
  end

  // ==========================================================================
  // Bus read ports
  // ==========================================================================
  // Data bus read returns the pre-write value, registered for one cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dataBusOut <= WORD_RESET;
    end else begin
      unique case (dataMemAccess.rdAddr)
        RA_X_A:     dataBusOut <= xOperand_reg[bank][0];
        RA_X_B:     dataBusOut <= xOperand_reg[bank][1];
        RA_Y_A:     dataBusOut <= yOperand_reg[bank][0];
        RA_Y_B:     dataBusOut <= yOperand_reg[bank][1];
        RA_ACC_LO:  dataBusOut <= accLow_reg[bank];
        RA_ACC_MID: dataBusOut <= accMid_reg[bank];
        RA_ACC_TOP: dataBusOut <= accTopExt;
        RA_NONE:    dataBusOut <= WORD_RESET;
      endcase
    end
  end

  // Result bus shows the selected accumulator section, top byte sign-extended.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resultBusOut <= WORD_RESET;
    end else begin
      unique case (cmd.xSel)
        XS_ACC_LO:  resultBusOut <= accLow_reg[bank];
        XS_ACC_TOP: resultBusOut <= accTopExt;
        default:    resultBusOut <= accMid_reg[bank];
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  ovf_update_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd.valid |=> multiplyOverflowFlag == $past(ovf))
    else $error("overflow flag not updated by operation");
  ovf_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cmd.valid |=> $stable(multiplyOverflowFlag))
    else $error("overflow flag changed without an operation");
  mid_sign_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_ACC_MID
    |=> accTop_reg[$past(bank)] == {8{$past(dataMemAccess.wrData[15])}})
    else $error("top byte not sign filled on middle load");
  low_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_ACC_LO
    |=> $stable(accMid_reg[bank]) && $stable(accTop_reg[bank]))
    else $error("low load disturbed upper sections");
  top_ext_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dataMemAccess.rdAddr == RA_ACC_TOP
    |=> dataBusOut[15:8] == {8{dataBusOut[7]}})
    else $error("top byte not sign extended on bus");
  clear_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd.valid && cmd.op == OP_CLEAR && !cmd.toFeedback && !dataMemAccess.wrEn
    ##1 $stable(modeStatus[BANK_BIT]) |-> accNow == 40'h0)
    else $error("clear did not zero accumulator");
  frac_lsb_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd.valid && cmd.op == OP_MUL && !modeStatus[INT_MODE_BIT] && !cmd.toFeedback
    && !dataMemAccess.wrEn |=> !accLow_reg[$past(bank)][0])
    else $error("fractional product lsb not zero");
  read_old_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dataMemAccess.wrEn && dataMemAccess.wrAddr == RA_X_A && dataMemAccess.rdAddr == RA_X_A
    |=> dataBusOut == $past(xOperand_reg[bank][0]))
    else $error("same cycle read did not return old value");
  fb_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd.valid && cmd.toFeedback |=> feedback_reg[$past(bank)] == $past(macResult[31:16]))
    else $error("feedback not loaded from result bits 16 to 31");
  // A result bound for the accumulator must be there one cycle after the operation.
  acc_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd.valid && !cmd.toFeedback && !dataMemAccess.wrEn
    |=> {accTop_reg[$past(bank)], accMid_reg[$past(bank)], accLow_reg[$past(bank)]}
        == $past(macResult))
    else $error("operation result not in accumulator next cycle");

  mac_add_c: cover property (@(posedge ref_clk) cmd.valid && cmd.op == OP_MAC_ADD);
  mac_sub_c: cover property (@(posedge ref_clk) cmd.valid && cmd.op == OP_MAC_SUB && ovf);
  alt_bank_c: cover property (@(posedge ref_clk) cmd.valid && bank);
  fb_loop_c: cover property (@(posedge ref_clk)
    cmd.valid && cmd.toFeedback ##1 cmd.valid && cmd.ySel == YS_FEEDBACK);

endmodule // multiply_accumulate_unit

// ===== bench/result_bus_model.sv
// Model of the other units' output registers that feed the X port over the result bus.
`timescale 1ns/1ps

module result_bus_model (
  input  wire logic        ref_clk,
  input  wire logic        loadEn,
  input  wire logic [47:0] loadData,
  output logic      [15:0] aluResult,
  output logic      [15:0] shifterResultLow,
  output logic      [15:0] shifterResultHigh
);
  // ==========================================================================
  // Output registers
  // ==========================================================================
  // The registers hold their value between loads, as real unit outputs do.
  always_ff @(posedge ref_clk) begin
    if (loadEn) begin
      {aluResult, shifterResultLow, shifterResultHigh} <= loadData;
    end
  end
endmodule // result_bus_model

// ===== bench/test_multiply_accumulate_unit.sv
// Self-checking testbench of the multiply/accumulate unit.
`timescale 1ns/1ps

module test_multiply_accumulate_unit import mac_unit_pkg::*; ;
  logic        ref_clk, rst_n, progBusWrEn, progBusSelB, srcLoad;
  logic        multiplyOverflowFlag, overflowValid;
  logic [15:0] modeStatus, progBusData, dataBusOut, resultBusOut;
  logic [15:0] aluResult, shifterResultLow, shifterResultHigh;
  logic [47:0] srcData;
  mac_cmd_t    cmd;
  dm_access_t  dataMemAccess;
  int          num_errors = 0;
  int          check_count = 0;

  // ==========================================================================
  // Design, partner and clock
  // ==========================================================================
  multiply_accumulate_unit dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .modeStatus(modeStatus),
    .cmd(cmd), .aluResult(aluResult), .shifterResultLow(shifterResultLow),
    .shifterResultHigh(shifterResultHigh), .dataMemAccess(dataMemAccess),
    .progBusWrEn(progBusWrEn), .progBusSelB(progBusSelB), .progBusData(progBusData),
    .dataBusOut(dataBusOut), .resultBusOut(resultBusOut),
    .multiplyOverflowFlag(multiplyOverflowFlag), .overflowValid(overflowValid));
  result_bus_model src_u (.ref_clk(ref_clk), .loadEn(srcLoad), .loadData(srcData),
    .aluResult(aluResult), .shifterResultLow(shifterResultLow),
    .shifterResultHigh(shifterResultHigh));
  // The clock toggles every half period of 2.5 ns.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chkWord(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkFlag(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkAcc(string what, logic [39:0] exp, logic [39:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Each task raises its own strobe and drops the others, so nothing toggles twice.
  task automatic wr(reg_addr_t a, logic [15:0] d);
    cmd.valid = 1'b0;
    dataMemAccess = '{1'b1, a, d, RA_NONE};
    tick();
  endtask
  task automatic rd(reg_addr_t a, output logic [15:0] d);
    cmd.valid = 1'b0;
    dataMemAccess = '{1'b0, RA_NONE, 16'h0000, a};
    tick();
    d = dataBusOut;
  endtask
  task automatic op(mac_op_t o, x_sel_t xs, y_sel_t ys, logic sx, logic sy, logic fb);
    dataMemAccess.wrEn = 1'b0;
    cmd = '{1'b1, o, xs, ys, sx, sy, fb};
    tick();
    chkFlag("overflowValid", 1'b1, overflowValid);
  endtask
  // Selects an accumulator section for the result bus without starting an operation.
  task automatic rbus(x_sel_t xs, logic [15:0] exp);
    dataMemAccess.wrEn = 1'b0;
    cmd = '{1'b0, OP_MUL, xs, YS_OPA, 1'b0, 1'b0, 1'b0};
    tick();
    chkWord("result bus", exp, resultBusOut);
  endtask
  task automatic rdAcc(output logic [39:0] v);
    logic [15:0] l, m, t;
    rd(RA_ACC_LO, l);
    rd(RA_ACC_MID, m);
    rd(RA_ACC_TOP, t);
    chkWord("top byte extension", {{8{t[7]}}, t[7:0]}, t);
    v = {t[7:0], m, l};
  endtask
  // Expected aligned product, widened by each operand's own signedness.
  function automatic logic [39:0] prod(logic [15:0] x, logic [15:0] y, logic sx, logic sy,
                                       logic intMode);
    logic signed [39:0] xe, ye, p;
    xe = {{24{sx & x[15]}}, x};
    ye = {{24{sy & y[15]}}, y};
    p = xe * ye;
    return intMode ? p : p << 1;
  endfunction

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic sc_loads();
    logic [39:0] v;
    rdAcc(v);
    chkAcc("accumulator after reset", 40'h0, v);
    wr(RA_ACC_LO, 16'h1234);
    wr(RA_ACC_MID, 16'h8001);
    rdAcc(v);
    chkAcc("middle load", 40'hff_8001_1234, v);
    rbus(XS_ACC_TOP, 16'hffff);
    rbus(XS_ACC_MID, 16'h8001);
    rbus(XS_ACC_LO, 16'h1234);
    wr(RA_ACC_TOP, 16'h0005);
    wr(RA_ACC_LO, 16'hbeef);
    rdAcc(v);
    chkAcc("top then low load", 40'h05_8001_beef, v);
  endtask
  task automatic sc_same();
    logic [15:0] d;
    logic [39:0] v;
    modeStatus = 16'h0010;
    wr(RA_X_A, 16'h2222);
    wr(RA_X_B, 16'h0003);
    wr(RA_Y_A, 16'h0002);
    // Multiply from one X register, write it and read the other in one cycle.
    cmd = '{1'b1, OP_MUL, XS_OPA, YS_OPA, 1'b0, 1'b0, 1'b0};
    dataMemAccess = '{1'b1, RA_X_A, 16'h0007, RA_X_B};
    tick();
    chkWord("x file bus port", 16'h0003, dataBusOut);
    rd(RA_X_A, d);
    chkWord("x file after write", 16'h0007, d);
    // Write and read the same X register in one cycle: the read sees the old value.
    dataMemAccess = '{1'b1, RA_X_A, 16'h0009, RA_X_A};
    tick();
    chkWord("x file same cycle read", 16'h0007, dataBusOut);
    rdAcc(v);
    chkAcc("product of old x", 40'h4444, v);
  endtask
  task automatic sc_modes();
    logic [39:0] v;
    wr(RA_X_A, 16'hc000);
    wr(RA_Y_A, 16'h8001);
    for (int i = 0; i < 8; i++) begin
      modeStatus = {11'h000, i[2], 4'h0};
      op(OP_MUL, XS_OPA, YS_OPA, i[1], i[0], 1'b0);
      rdAcc(v);
      chkAcc("product format", prod(16'hc000, 16'h8001, i[1], i[0], i[2]), v);
    end
  endtask
  task automatic sc_mac();
    logic [39:0] v;
    modeStatus = 16'h0010;
    wr(RA_X_A, 16'h0001);
    wr(RA_Y_A, 16'h0001);
    wr(RA_ACC_MID, 16'h7fff);
    wr(RA_ACC_LO, 16'hffff);
    op(OP_MAC_ADD, XS_OPA, YS_OPA, 1'b1, 1'b1, 1'b0);
    chkFlag("overflow after add", 1'b1, multiplyOverflowFlag);
    op(OP_MAC_SUB, XS_OPA, YS_OPA, 1'b1, 1'b1, 1'b0);
    chkFlag("overflow after sub", 1'b0, multiplyOverflowFlag);
    rdAcc(v);
    chkAcc("add then subtract", 40'h00_7fff_ffff, v);
    op(OP_CLEAR, XS_OPA, YS_OPA, 1'b1, 1'b1, 1'b0);
    rdAcc(v);
    chkAcc("clear", 40'h0, v);
  endtask
  task automatic sc_feedback();
    logic [39:0] v;
    wr(RA_X_A, 16'h0100);
    wr(RA_Y_A, 16'h0300);
    op(OP_MUL, XS_OPA, YS_OPA, 1'b0, 1'b0, 1'b1);
    rdAcc(v);
    chkAcc("accumulator kept", 40'h0, v);
    op(OP_MUL, XS_OPA, YS_FEEDBACK, 1'b0, 1'b0, 1'b0);
    rdAcc(v);
    chkAcc("feedback as y", 40'h300, v);
  endtask
  task automatic sc_xsrc();
    logic [39:0] v, e;
    logic [15:0] s;
    wr(RA_X_A, 16'h0021);
    wr(RA_X_B, 16'h0022);
    wr(RA_Y_A, 16'h0001);
    e = 40'h300;
    for (int i = 0; i < 8; i++) begin
      case (x_sel_t'(i))
        XS_OPA:     s = 16'h0021;
        XS_OPB:     s = 16'h0022;
        XS_ALU:     s = 16'h0011;
        XS_ACC_LO:  s = e[15:0];
        XS_ACC_MID: s = e[31:16];
        XS_ACC_TOP: s = {{8{e[39]}}, e[39:32]};
        XS_SHF_LO:  s = 16'h0012;
        default:    s = 16'h0013;
      endcase
      op(OP_MUL, x_sel_t'(i), YS_OPA, 1'b0, 1'b0, 1'b0);
      rdAcc(v);
      e = {24'h000000, s};
      chkAcc("x source", e, v);
    end
  endtask
  task automatic sc_bank();
    logic [15:0] d;
    logic [39:0] v;
    modeStatus = 16'h0011;
    wr(RA_X_A, 16'haaaa);
    // Program-bus write of the second Y register in the alternate bank.
    dataMemAccess.wrEn = 1'b0;
    progBusWrEn = 1'b1;
    progBusSelB = 1'b1;
    progBusData = 16'h5a5a;
    tick();
    progBusWrEn = 1'b0;
    rd(RA_Y_B, d);
    chkWord("program bus write", 16'h5a5a, d);
    op(OP_MUL, XS_OPA, YS_OPB, 1'b0, 1'b0, 1'b0);
    rdAcc(v);
    chkAcc("alternate bank product", prod(16'haaaa, 16'h5a5a, 1'b0, 1'b0, 1'b1), v);
    modeStatus = 16'h0010;
    rd(RA_X_A, d);
    chkWord("primary bank x", 16'h0021, d);
    rd(RA_Y_B, d);
    chkWord("primary bank y", 16'h0000, d);
    wr(RA_Y_B, 16'h0f0f);
    rd(RA_Y_B, d);
    chkWord("data bus y write", 16'h0f0f, d);
    // Program-bus write of the first Y register, then both Y registers as operands.
    progBusWrEn = 1'b1;
    progBusSelB = 1'b0;
    progBusData = 16'h0003;
    tick();
    progBusWrEn = 1'b0;
    op(OP_MUL, XS_OPA, YS_OPA, 1'b0, 1'b0, 1'b0);
    rdAcc(v);
    chkAcc("program bus y operand", 40'h63, v);
    op(OP_MUL, XS_OPA, YS_OPB, 1'b0, 1'b0, 1'b0);
    rdAcc(v);
    chkAcc("second y operand", prod(16'h0021, 16'h0f0f, 1'b0, 1'b0, 1'b1), v);
  endtask

  // ==========================================================================
  // Sequence, verdict and watchdog
  // ==========================================================================
  task automatic results();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset for three cycles, then run every scenario in turn.
  initial begin
    rst_n = 1'b0;
    modeStatus = 16'h0000;
    cmd = '0;
    dataMemAccess = '{1'b0, RA_NONE, 16'h0000, RA_NONE};
    {progBusWrEn, progBusSelB, progBusData} = '0;
    srcLoad = 1'b1;
    srcData = 48'h0011_0012_0013;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    srcLoad = 1'b0;
    tick();
    sc_loads();
    sc_same();
    sc_modes();
    sc_mac();
    sc_feedback();
    sc_xsrc();
    sc_bank();
    results();
  end
  // The scenarios need well under a thousand cycles; this cuts a hang short.
  initial begin
    #20000;
    num_errors++;
    results();
  end
endmodule // test_multiply_accumulate_unit
